// *** inc/arb_if.sv ***
// Handshake between the recognizer and the serial contention arbiter
`default_nettype none
interface arb_if;
	logic                  start;
	logic [3:0]            cand;
	irq_pkg::prio_field_t  fields [4];
	logic                  done;
	irq_pkg::src_idx_t     winner;
	irq_pkg::prio_field_t  winField;
	modport requester (output start, output cand, output fields, input done, input winner, input winField);
	modport arbiter (input start, input cand, input fields, output done, output winner, output winField);
endinterface
`default_nettype wire

// *** inc/irq_pkg.sv ***
// Types shared by the interrupt recognizer and its contention arbiter
package irq_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARB  = 2'b01,
		ST_TERM = 2'b10
	} ack_state_t;
	typedef logic [1:0] src_idx_t;
	typedef logic [3:0] prio_field_t;
endpackage

// *** inc/irq_regs.svh ***
// Register offsets, field positions, reset values and vector numbers of the interrupt recognizer
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH
`define IRQ_OFF_STATUS     8'h00
`define IRQ_OFF_VBASE      8'h04
`define IRQ_OFF_CONTEND    8'h08
`define IRQ_OFF_PENDING    8'h0C
`define IRQ_OFF_LASTEXC    8'h10
`define IRQ_BIT_TRACEHI    15
`define IRQ_BIT_TRACELO    14
`define IRQ_BIT_SUPER      13
`define IRQ_MASK_HI        10
`define IRQ_MASK_LO        8
`define IRQ_RST_MASK       3'h7
`define IRQ_RST_VBASE      32'h0000_0000
`define IRQ_RST_CONTEND    16'h000F
`define IRQ_TOP_LEVEL      3'h7
`define IRQ_SPACE_FC       3'h7
`define IRQ_ACK_ADDR_HI    20'hFFFFF
`define IRQ_VEC_SPURIOUS   8'h18
`define IRQ_VEC_AUTO_BASE  8'h18
`define IRQ_VEC_USER_FIRST 8'h38
`define IRQ_NUM_SRC        4
`define IRQ_FIELD_BITS     4
`endif

// *** rtl/irq_contention.sv ***
// Serial bit-by-bit contention of four-bit priority fields, most significant bit first
`default_nettype none
`include "irq_regs.svh"
module irq_contention (
	input  wire logic clk,     // System clock
	input  wire logic rst,     // Master reset
	arb_if.arbiter    arb      // Contention request and result
);
	logic [3:0] alive_reg;
	logic [1:0] bitIdx_reg;
	logic       busy_reg;
	logic [3:0] column;

	// Column of the current bit over the sources still contending
	always_comb
	begin
		for (int i = 0; i < `IRQ_NUM_SRC; i++)
			column[i] = alive_reg[i] & arb.fields[i][bitIdx_reg];
	end

	// A source showing 0 where another shows 1 drops out; four steps decide
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			alive_reg  <= 4'h0;
			bitIdx_reg <= 2'h3;
			busy_reg   <= 1'b0;
			arb.done   <= 1'b0;
		end
		else
		begin
			arb.done <= 1'b0;
			if (arb.start && !busy_reg)
			begin
				alive_reg  <= arb.cand;
				bitIdx_reg <= 2'h3;
				busy_reg   <= 1'b1;
			end
			else if (busy_reg)
			begin
				if (|column)
					alive_reg <= column;
				bitIdx_reg <= bitIdx_reg - 2'h1;
				if (bitIdx_reg == 2'h0)
				begin
					busy_reg <= 1'b0;
					arb.done <= 1'b1;
				end
			end
		end
	end

	// Winner is the lowest surviving index; unique fields leave exactly one
	always_comb
	begin
		arb.winner = 2'h0;
		for (int i = `IRQ_NUM_SRC - 1; i >= 0; i--)
			if (alive_reg[i])
				arb.winner = i[1:0];
		arb.winField = arb.fields[arb.winner];
	end
endmodule // irq_contention
`default_nettype wire

// *** rtl/irq_recognizer.sv ***
// Interrupt recognition, priority mask, acknowledge cycle and vector generation
//
// Summary of operation
// - Seven request levels, seven highest, one lowest
// - Seven autovectors plus 200 assignable vectors; the code accepts any vector number the winner gives
// - Three-bit mask; ignore levels at or below
// - Level seven recognised even at mask seven
// - Level seven needs a fresh falling transition
// - Mask write under held seven re-requests
// - Request lines sampled on successive clock edges
// - Valid only after two consecutive asserted samples
// - Valid requests wait for instruction boundary
// - Pending level not latched; higher one wins
// - Simultaneous unmasked requests: higher level recognised
// - Pin requests count as integration unit's
// - Recognition starts a processor-space acknowledge read
// - Acknowledged level copied into the mask
// - Contention serially compares four-bit priority fields
// - Zero field winner gives spurious exception
// - Reset clears trace, sets supervisor, mask seven
// - Reset clears vector table base to zero
// - Ack cycle: code ones, address ones, level
// - Reset fields: unit fifteen, modules zero
`default_nettype none
`include "irq_regs.svh"
module irq_recognizer (
	input  wire logic        clk,          // 40 MHz system clock
	input  wire logic        rst,          // Master reset, synchronous
	input  wire logic        wbCyc,        // Wishbone cycle
	input  wire logic        wbStb,        // Wishbone strobe
	input  wire logic        wbWe,         // Wishbone write enable
	input  wire logic [7:0]  wbAdr,        // Wishbone byte address
	input  wire logic [3:0]  wbSel,        // Wishbone byte lanes
	input  wire logic [31:0] wbDatI,       // Wishbone write data
	output logic      [31:0] wbDatO,       // Wishbone read data
	output logic             wbAck,        // Wishbone acknowledge
	input  wire logic [7:1]  reqPin_n,     // Request pins, active low
	input  wire logic [8:0]  modLevel,     // Three internal modules, 3-bit level each
	input  wire logic        instrBoundary,// Core at an instruction boundary
	input  wire logic        termVector,   // Winner supplied vector with size acknowledge
	input  wire logic [7:0]  vectorIn,     // Vector number from winner
	input  wire logic        termAuto,     // Autovector request
	input  wire logic        termFault,    // Bus fault during acknowledge
	output logic             ackRead,      // Acknowledge read issued, pulse
	output logic             ackActive,    // Acknowledge cycle in progress
	output logic      [2:0]  ackFc,        // Function code lines
	output logic      [23:0] ackAddr,      // Acknowledge address
	output logic      [2:0]  ackLevel,     // Level being acknowledged
	output logic      [1:0]  winnerId,     // Contention winner, 0 is integration unit
	output logic             excValid,     // Vector ready, pulse
	output logic      [7:0]  excVector,    // Vector number
	output logic      [31:0] excAddr       // Vector address
);
	logic [7:1]  pinS1_reg, pinS2_reg, pinS3_reg, pinStable_reg;
	logic [7:1]  reqRaw, sampA_reg, reqValid_reg;
	logic        prevValid7_reg;
	logic        nmiPend_reg;
	logic [2:0]  mask_reg;
	logic        super_reg, traceHi_reg, traceLo_reg;
	logic [31:0] vbase_reg;
	logic [15:0] contend_reg;
	irq_pkg::ack_state_t state_reg;
	logic [7:1]  eligible;
	logic [2:0]  recLevel;
	logic        busReq, busWrite, maskWrite;
	logic [3:0]  cand;
	arb_if       arb ();

	// Byte-lane merge of a write into a 32-bit register
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		for (int b = 0; b < 4; b++)
			laneMerge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
	endfunction

	// Highest set level of a request vector, zero when none
	function automatic logic [2:0] topLevel(input logic [7:1] v);
		topLevel = 3'h0;
		for (int l = 1; l <= 7; l++)
			if (v[l])
				topLevel = l[2:0];
	endfunction

	// Pins cross into the clock domain; a change counts once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pinS1_reg     <= 7'h7F;
			pinS2_reg     <= 7'h7F;
			pinS3_reg     <= 7'h7F;
			pinStable_reg <= 7'h7F;
		end
		else
		begin
			pinS1_reg <= reqPin_n;
			pinS2_reg <= pinS1_reg;
			pinS3_reg <= pinS2_reg;
			for (int l = 1; l <= 7; l++)
				if (pinS2_reg[l] == pinS3_reg[l])
					pinStable_reg[l] <= pinS3_reg[l];
		end
	end

	// Pin requests join module requests as if the integration unit raised them
	always_comb
	begin
		reqRaw = ~pinStable_reg;
		for (int m = 0; m < 3; m++)
			for (int l = 1; l <= 7; l++)
				if (modLevel[m*3 +: 3] == l[2:0])
					reqRaw[l] = 1'b1;
	end

	// Every edge is one sample; two asserted in a row make a level valid
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sampA_reg    <= 7'h00;
			reqValid_reg <= 7'h00;
		end
		else
		begin
			sampA_reg    <= reqRaw;
			reqValid_reg <= reqRaw & sampA_reg;
		end
	end

	// Level seven only by transition, so a line held low is served once
	always_ff @(posedge clk)
	begin
		if (rst)
			prevValid7_reg <= 1'b0;
		else
			prevValid7_reg <= reqValid_reg[7];
	end

	// Bus request and write detection
	assign busReq    = wbCyc && wbStb && !wbAck;
	assign busWrite  = busReq && wbWe;
	assign maskWrite = busWrite && (wbAdr == `IRQ_OFF_STATUS) && wbSel[1];

	// Non-maskable request flag; a new event wins over the acknowledge clear
	always_ff @(posedge clk)
	begin
		if (rst)
			nmiPend_reg <= 1'b0;
		else if ((reqValid_reg[7] && !prevValid7_reg) || (maskWrite && reqValid_reg[7]))
			nmiPend_reg <= 1'b1;
		else if (arb.done && ackLevel == `IRQ_TOP_LEVEL)
			nmiPend_reg <= 1'b0;
	end

	// Levels above the mask, level seven regardless of mask; not latched, recomputed each cycle
	always_comb
	begin
		eligible = 7'h00;
		for (int l = 1; l < 7; l++)
			eligible[l] = reqValid_reg[l] && (l[2:0] > mask_reg);
		eligible[7] = nmiPend_reg;
		recLevel = topLevel(eligible);
	end

	// Sources requesting at the level being acknowledged join contention
	always_comb
	begin
		cand[0] = ~pinStable_reg[ackLevel == 3'h0 ? 1 : ackLevel];
		for (int m = 0; m < 3; m++)
			cand[m+1] = (modLevel[m*3 +: 3] == ackLevel);
		for (int s = 0; s < `IRQ_NUM_SRC; s++)
			arb.fields[s] = contend_reg[s*4 +: 4];
	end
	assign arb.cand  = cand;
	assign arb.start = (state_reg == irq_pkg::ST_ARB);

	irq_contention u_contention (
		.clk (clk),
		.rst (rst),
		.arb (arb)
	);

	// Acknowledge sequencer: wait for a boundary, contend, issue the read, terminate
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg <= irq_pkg::ST_IDLE;
			ackLevel  <= 3'h0;
			ackRead   <= 1'b0;
			ackActive <= 1'b0;
			ackFc     <= 3'h0;
			ackAddr   <= 24'h000000;
			winnerId  <= 2'h0;
			excValid  <= 1'b0;
			excVector <= 8'h00;
			excAddr   <= 32'h0000_0000;
		end
		else
		begin
			ackRead  <= 1'b0;
			excValid <= 1'b0;
			unique case (state_reg)
				irq_pkg::ST_IDLE:
				begin
					if (instrBoundary && recLevel != 3'h0)
					begin
						ackLevel  <= recLevel;
						state_reg <= irq_pkg::ST_ARB;
					end
				end
				irq_pkg::ST_ARB:
				begin
					if (arb.done)
					begin
						ackRead   <= 1'b1;
						ackActive <= 1'b1;
						winnerId  <= arb.winner;
						ackFc     <= `IRQ_SPACE_FC;
						ackAddr   <= {`IRQ_ACK_ADDR_HI, ackLevel, 1'b1};
						state_reg <= irq_pkg::ST_TERM;
					end
				end
				irq_pkg::ST_TERM:
				begin
					if (ackRead && arb.winField == 4'h0)
					begin
						excVector <= `IRQ_VEC_SPURIOUS;
						excAddr   <= vbase_reg + {22'h0, `IRQ_VEC_SPURIOUS, 2'h0};
						excValid  <= 1'b1;
						ackActive <= 1'b0;
						state_reg <= irq_pkg::ST_IDLE;
					end
					else if (termVector || termAuto || termFault)
					begin
						// Fault outranks the others; the vector pool is any number the winner gives
						if (termFault)
						begin
							excVector <= `IRQ_VEC_SPURIOUS;
							excAddr   <= vbase_reg + {22'h0, `IRQ_VEC_SPURIOUS, 2'h0};
						end
						else if (termAuto)
						begin
							excVector <= `IRQ_VEC_AUTO_BASE + {5'h0, ackLevel};
							excAddr   <= vbase_reg + {22'h0, `IRQ_VEC_AUTO_BASE + {5'h0, ackLevel}, 2'h0};
						end
						else
						begin
							excVector <= vectorIn;
							excAddr   <= vbase_reg + {22'h0, vectorIn, 2'h0};
						end
						excValid  <= 1'b1;
						ackActive <= 1'b0;
						state_reg <= irq_pkg::ST_IDLE;
					end
				end
				default:
					state_reg <= irq_pkg::ST_IDLE;
			endcase
		end
	end

	// Status bits; the acknowledged level enters the mask as the read issues
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mask_reg    <= `IRQ_RST_MASK;
			super_reg   <= 1'b1;
			traceHi_reg <= 1'b0;
			traceLo_reg <= 1'b0;
		end
		else if (state_reg == irq_pkg::ST_ARB && arb.done)
		begin
			mask_reg    <= ackLevel;
			super_reg   <= 1'b1;
			traceHi_reg <= 1'b0;
			traceLo_reg <= 1'b0;
		end
		else if (maskWrite)
		begin
			mask_reg    <= wbDatI[`IRQ_MASK_HI:`IRQ_MASK_LO];
			super_reg   <= wbDatI[`IRQ_BIT_SUPER];
			traceHi_reg <= wbDatI[`IRQ_BIT_TRACEHI];
			traceLo_reg <= wbDatI[`IRQ_BIT_TRACELO];
		end
	end

	// Vector base and contention fields written by software
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			vbase_reg   <= `IRQ_RST_VBASE;
			contend_reg <= `IRQ_RST_CONTEND;
		end
		else if (busWrite)
		begin
			if (wbAdr == `IRQ_OFF_VBASE)
				vbase_reg <= laneMerge(vbase_reg, wbDatI, wbSel);
			if (wbAdr == `IRQ_OFF_CONTEND)
				contend_reg <= 16'(laneMerge({16'h0, contend_reg}, wbDatI, wbSel));
		end
	end

	// Single-wait slave: ack one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wbAck  <= 1'b0;
			wbDatO <= 32'h0000_0000;
		end
		else
		begin
			wbAck  <= busReq;
			wbDatO <= 32'h0000_0000;
			if (busReq && !wbWe)
			begin
				unique case (wbAdr)
					`IRQ_OFF_STATUS:  wbDatO <= {16'h0, traceHi_reg, traceLo_reg, super_reg, 2'h0, mask_reg, 8'h00};
					`IRQ_OFF_VBASE:   wbDatO <= vbase_reg;
					`IRQ_OFF_CONTEND: wbDatO <= {16'h0, contend_reg};
					`IRQ_OFF_PENDING: wbDatO <= {21'h0, state_reg, nmiPend_reg, reqValid_reg, 1'b0};
					`IRQ_OFF_LASTEXC: wbDatO <= {16'h0, 6'h0, winnerId, excVector};
					default:          wbDatO <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Checks
	sequence s_issue;
		ackRead && ackFc == 3'h7;
	endsequence
	sequence s_spur;
		excValid && excVector == 8'h18;
	endsequence

	property p_reset;
		@(posedge clk) rst |=> mask_reg == 3'h7 && super_reg && !traceHi_reg && !traceLo_reg && vbase_reg == 32'h0;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

	property p_fields;
		@(posedge clk) rst |=> contend_reg == 16'h000F;
	endproperty
	a_fields: assert property (p_fields) else $error("contention fields reset wrong");

	property p_twoSamples;
		@(posedge clk) disable iff (rst) ##2 (reqValid_reg == ($past(reqRaw, 1) & $past(reqRaw, 2)));
	endproperty
	a_twoSamples: assert property (p_twoSamples) else $error("request validated early");

	property p_nmiEdge;
		@(posedge clk) disable iff (rst) (reqValid_reg[7] && !prevValid7_reg) |=> nmiPend_reg;
	endproperty
	a_nmiEdge: assert property (p_nmiEdge) else $error("level seven edge lost");

	property p_maskWrite;
		@(posedge clk) disable iff (rst) (maskWrite && reqValid_reg[7]) |=> nmiPend_reg;
	endproperty
	a_maskWrite: assert property (p_maskWrite) else $error("mask write missed request");

	property p_wait;
		@(posedge clk) disable iff (rst) (state_reg == irq_pkg::ST_IDLE && !instrBoundary) |=> state_reg == irq_pkg::ST_IDLE;
	endproperty
	a_wait: assert property (p_wait) else $error("serviced off boundary");

	property p_highest;
		@(posedge clk) disable iff (rst) (recLevel != 3'h0) |-> (eligible >> recLevel) == 7'h00;
	endproperty
	a_highest: assert property (p_highest) else $error("lower level chosen");

	property p_addr;
		@(posedge clk) disable iff (rst) s_issue |-> ackAddr == {20'hFFFFF, ackLevel, 1'b1} && ackActive;
	endproperty
	a_addr: assert property (p_addr) else $error("acknowledge address wrong");

	property p_latch;
		@(posedge clk) disable iff (rst) ackRead |-> mask_reg == ackLevel && mask_reg == $past(recLevel, 7);
	endproperty
	a_latch: assert property (p_latch) else $error("mask not loaded");

	property p_spurious;
		@(posedge clk) disable iff (rst) (s_issue ##0 arb.winField == 4'h0) |=> s_spur;
	endproperty
	a_spurious: assert property (p_spurious) else $error("zero field not spurious");

	property p_arbTime;
		@(posedge clk) disable iff (rst) $rose(state_reg == irq_pkg::ST_ARB) |-> ##[1:6] ackRead;
	endproperty
	a_arbTime: assert property (p_arbTime) else $error("contention overran");
endmodule // irq_recognizer
`default_nettype wire

// *** test/irq_source_model.sv ***
// Behavioural model of the interrupt requesters and acknowledge responders
`default_nettype none
module irq_source_model (
	input  wire logic       clk,        // System clock
	input  wire logic       ackRead,    // Acknowledge read pulse
	input  wire logic       ackActive,  // Acknowledge cycle running
	input  wire logic [2:0] ackLevel,   // Level being acknowledged
	input  wire logic [1:0] winnerId,   // Contention winner
	output logic      [7:1] reqPin_n,   // Pin requests, active low
	output logic      [8:0] modLevel,   // Module request levels
	output logic            termVector, // Vector with size acknowledge
	output logic      [7:0] vectorIn,   // Vector number
	output logic            termAuto,   // Autovector request
	output logic            termFault   // Bus fault
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] lvl [4];
	logic       sticky;
	logic [1:0] termMode;
	int         termDelay;
	int         waitCnt;
	logic [7:0] noise;
	// Idle levels at time zero; the bench sets requests and answer style
	initial
	begin
		lvl = '{default: 3'h0};
		sticky = 1'b0;
		termMode = 2'h0;
		termDelay = 1;
		waitCnt = 0;
		noise = 8'h00;
		reqPin_n = 7'h7F;
		modLevel = 9'h000;
		{termVector, termAuto, termFault} = 3'h0;
		vectorIn = 8'hA5;
	end
	// Requests stay asserted until they win the acknowledge of their own level; while sticky is set they are never released
	always @(posedge clk)
	begin
		reqPin_n <= (lvl[0] == 3'h0) ? 7'h7F : ~(7'h01 << (lvl[0] - 3'h1));
		modLevel <= {lvl[3], lvl[2], lvl[1]};
		if (ackRead === 1'b1 && !sticky && lvl[winnerId] == ackLevel)
			lvl[winnerId] <= 3'h0;
	end
	// Only the winner answers, after a chosen delay; the data bus floats otherwise
	always @(posedge clk)
	begin
		noise <= noise + 8'h5B;
		waitCnt <= (ackActive === 1'b1) ? waitCnt + 1 : 0;
		{termVector, termAuto, termFault} <= 3'h0;
		vectorIn <= ~noise;
		if (ackActive === 1'b1 && waitCnt == termDelay)
		begin
			case (termMode)
				2'h1: termAuto <= 1'b1;
				2'h2: termFault <= 1'b1;
				default:
				begin
					termVector <= 1'b1;
					vectorIn <= 8'h40 + {6'h0, winnerId};
				end
			endcase
		end
	end
endmodule // irq_source_model
`default_nettype wire

// *** test/tb_irq_recognizer.sv ***
// Self-checking bench for the interrupt recognizer
`default_nettype none
module tb_irq_recognizer;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, instrBoundary = 1'b1;
	logic [7:0]  wbAdr = 8'h00;
	logic [3:0]  wbSel = 4'h0, lanes = 4'hF;
	logic [31:0] wbDatI = 32'h0, vbase = 32'h0, seed = 32'h00000054;
	logic [31:0] wbDatO, excAddr, rd, r;
	logic        wbAck, ackRead, ackActive, excValid, termVector, termAuto, termFault;
	logic [7:1]  reqPin_n;
	logic [8:0]  modLevel;
	logic [2:0]  ackFc, ackLevel, top;
	logic [23:0] ackAddr;
	logic [1:0]  winnerId, w;
	logic [7:0]  vectorIn, excVector;
	logic [3:0]  fld [4];
	logic [2:0]  lv [4];
	int          num_errors = 0, tests_run = 0, ackCount = 0, a;
	bit          found;
	// Clock at 40 MHz
	always #12.5 clk = ~clk;
	irq_recognizer dut_u (.clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
		.wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .reqPin_n(reqPin_n),
		.modLevel(modLevel), .instrBoundary(instrBoundary), .termVector(termVector), .vectorIn(vectorIn),
		.termAuto(termAuto), .termFault(termFault), .ackRead(ackRead), .ackActive(ackActive), .ackFc(ackFc),
		.ackAddr(ackAddr), .ackLevel(ackLevel), .winnerId(winnerId), .excValid(excValid),
		.excVector(excVector), .excAddr(excAddr));
	irq_source_model src_u (.clk(clk), .ackRead(ackRead), .ackActive(ackActive), .ackLevel(ackLevel),
		.winnerId(winnerId), .reqPin_n(reqPin_n), .modLevel(modLevel), .termVector(termVector),
		.vectorIn(vectorIn), .termAuto(termAuto), .termFault(termFault));
	// Count acknowledge reads so that silence can be proven
	always @(posedge clk)
	begin
		if (ackRead === 1'b1)
			ackCount <= ackCount + 1;
	end
	task automatic report_and_stop();
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Vector the core should take for each way of ending the acknowledge
	function automatic logic [7:0] expVec(input logic [1:0] m, input logic [2:0] l, input logic [1:0] id);
		case (m)
			2'h1: return 8'h18 + {5'h0, l};
			2'h2: return 8'h18;
			default: return 8'h40 + {6'h0, id};
		endcase
	endfunction
	// One classic Wishbone cycle; request held until ack is sampled
	task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'b11, we, adr, lanes, dat};
		do
			@(posedge clk);
		while (wbAck !== 1'b1 && ++n < 20);
		rd = wbDatO;
		{wbCyc, wbStb, wbWe} <= 3'b000;
		if (wbAck !== 1'b1)
			check("wbAck", 1'b0, 1'b1);
	endtask
	// Follow one acknowledge from the read to the vector and the new mask
	task automatic service(input logic [2:0] l, input logic [1:0] id, input logic [7:0] v, input bit chkW);
		int n;
		n = 0;
		do
			@(posedge clk);
		while (ackRead !== 1'b1 && ++n < 100);
		check("ackRead", ackRead, 1'b1);
		check("ackLevel", ackLevel, l);
		check("ackAddr", ackAddr, {20'hFFFFF, l, 1'b1});
		check("ackFc", ackFc, 3'h7);
		check("ackActive", ackActive, 1'b1);
		if (chkW)
			check("winnerId", winnerId, id);
		n = 0;
		do
			@(posedge clk);
		while (excValid !== 1'b1 && ++n < 100);
		check("excVector", excVector, v);
		check("excAddr", excAddr, vbase + {22'h0, v, 2'b00});
		check("ackActive end", ackActive, 1'b0);
		wbXfer(1'b0, 8'h10, 32'h0);
		check("lastexc", rd & (chkW ? 32'h000003FF : 32'h000000FF), {22'h0, chkW ? id : 2'h0, v});
		wbXfer(1'b0, 8'h00, 32'h0);
		check("status", rd & 32'h0000E700, 32'h00002000 | {21'h0, l, 8'h00});
	endtask
	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (40000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wbXfer(1'b0, 8'h00, 32'h0);
		check("status rst", rd & 32'h0000E700, 32'h00002700);
		wbXfer(1'b0, 8'h04, 32'h0);
		check("vbase rst", rd, 32'h0);
		wbXfer(1'b0, 8'h08, 32'h0);
		check("fields rst", rd, 32'h0000000F);
		wbXfer(1'b1, 8'h20, 32'hFFFFFFFF);
		wbXfer(1'b0, 8'h20, 32'h0);
		check("unmapped", rd, 32'h0);
		// Status write without byte lane one must leave the mask alone
		lanes = 4'h1;
		wbXfer(1'b1, 8'h00, 32'h0);
		lanes = 4'hF;
		wbXfer(1'b0, 8'h00, 32'h0);
		check("status lanes", rd & 32'h0000E700, 32'h00002700);
		// Level three under mask seven, then off-boundary with a higher pin level joining
		src_u.lvl[1] <= 3'h3;
		repeat (20) @(posedge clk);
		check("masked", ackCount, 0);
		instrBoundary <= 1'b0;
		wbXfer(1'b1, 8'h00, 32'h00002200);
		src_u.lvl[0] <= 3'h5;
		repeat (20) @(posedge clk);
		check("boundary", ackCount, 0);
		instrBoundary <= 1'b1;
		service(3'h5, 2'h0, 8'h40, 1'b1);
		wbXfer(1'b1, 8'h00, 32'h00002200);
		service(3'h3, 2'h1, 8'h18, 1'b0);
		src_u.lvl[1] <= 3'h0;
		// Held level seven: only a fresh edge or a mask write brings it back
		wbXfer(1'b1, 8'h00, 32'h00002700);
		src_u.sticky <= 1'b1;
		src_u.lvl[0] <= 3'h7;
		service(3'h7, 2'h0, 8'h40, 1'b1);
		a = ackCount;
		repeat (30) @(posedge clk);
		check("held seven", ackCount, a);
		wbXfer(1'b0, 8'h0C, 32'h0);
		check("pending", rd, 32'h00000080);
		wbXfer(1'b1, 8'h00, 32'h00002700);
		service(3'h7, 2'h0, 8'h40, 1'b1);
		src_u.sticky <= 1'b0;
		src_u.lvl[0] <= 3'h0;
		repeat (10) @(posedge clk);
		// Random rounds: unique nonzero fields, mixed levels and answer styles
		for (int k = 0; k < 40; k++)
		begin
			r = rnd();
			for (int i = 0; i < 4; i++)
				fld[i] = 4'((r[7:0] % 15 + 4 * i) % 15 + 1);
			vbase = rnd();
			wbXfer(1'b1, 8'h04, vbase);
			wbXfer(1'b1, 8'h08, {16'h0, fld[3], fld[2], fld[1], fld[0]});
			// Mask seven first, so no new level is served before the bench expects it
			wbXfer(1'b1, 8'h00, 32'h00002700);
			src_u.termMode <= r[9:8];
			src_u.termDelay <= int'(r[12:10]) + 1;
			for (int i = 0; i < 4; i++)
				lv[i] = 3'(r[15 + 3 * i +: 3] % 7);
			if (lv[1] == 3'h0)
				lv[1] = 3'h1;
			for (int i = 0; i < 4; i++)
				src_u.lvl[i] <= lv[i];
			repeat (10) @(posedge clk);
			while (lv[0] != 3'h0 || lv[1] != 3'h0 || lv[2] != 3'h0 || lv[3] != 3'h0)
			begin
				top = 3'h0;
				found = 1'b0;
				for (int i = 0; i < 4; i++)
					if (lv[i] > top)
						top = lv[i];
				for (int i = 0; i < 4; i++)
					if (lv[i] == top && (!found || fld[i] > fld[w]))
					begin
						w = 2'(i);
						found = 1'b1;
					end
				wbXfer(1'b1, 8'h00, 32'h00002000);
				service(top, w, expVec(r[9:8], top, w), 1'b1);
				lv[w] = 3'h0;
				repeat (10) @(posedge clk);
			end
		end
		report_and_stop();
	end
endmodule // tb_irq_recognizer
`default_nettype wire
